/* File: core/psal_pkg.sv */
// shared constants for the status and alarm logic
package psal_pkg;
    localparam int  CLK_MHZ           = 250;
    localparam int  PULSE_PERIOD_US   = 1000;
    localparam int  PULSE_CYCLES      = PULSE_PERIOD_US * CLK_MHZ;
    localparam int  HALF_CYCLES       = PULSE_CYCLES / 2;
    localparam int  BLINK_PERIOD_MS   = 500;
    localparam int  BLINK_HALF_CYCLES = BLINK_PERIOD_MS * 1000 * CLK_MHZ / 2;
    localparam int  ADDR_W            = 4;
    localparam int  STICKY_W          = 12;
    // sticky bit positions
    localparam int  ST_OV      = 0;
    localparam int  ST_UV      = 1;
    localparam int  ST_OC      = 2;
    localparam int  ST_FAN     = 3;
    localparam int  ST_INPUT   = 4;
    localparam int  ST_UNKNOWN = 5;
    localparam int  ST_CML     = 6;
    localparam int  ST_INTEXT  = 7;
    localparam int  ST_SHUTDN  = 8;
    localparam int  ST_ORPASS  = 9;
    localparam int  ST_ORFAIL  = 10;
    localparam int  ST_OT      = 11;
    localparam logic [11:0] STICKY_RST = 12'h000;
    localparam logic [1:0]  RESP_RST   = 2'h0;
    typedef enum logic [1:0] {PSAL_PROTO_PMBUS, PSAL_PROTO_OTHER} psal_proto_t;
endpackage

/* File: core/psal_tick_if.sv */
// blink and pulse timing signals shared between modules
`timescale 1ns/1ns
`default_nettype none
interface psal_tick_if;
    logic pulse_phase;
    logic blink_phase;
    modport src (output pulse_phase, output blink_phase);
    modport dst (input pulse_phase, input blink_phase);
endinterface
`default_nettype wire

/* File: core/psal_timer.sv */
// square-wave phase generator for pulse and blink
`timescale 1ns/1ns
`default_nettype none
module psal_timer #(
    parameter int PULSE_HALF = psal_pkg::HALF_CYCLES,
    parameter int BLINK_HALF = psal_pkg::BLINK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   reset,
    // phases
    psal_tick_if.src    tk
);
    logic [31:0] pcnt_ff, nxt_pcnt;
    logic [31:0] bcnt_ff, nxt_bcnt;
    logic        pph_ff,  nxt_pph;
    logic        bph_ff,  nxt_bph;

    always_comb begin
        nxt_pcnt = pcnt_ff + 32'h1;
        nxt_pph  = pph_ff;
        if (pcnt_ff >= 32'(PULSE_HALF - 1)) begin
            nxt_pcnt = 32'h0;
            nxt_pph  = ~pph_ff;
        end
        nxt_bcnt = bcnt_ff + 32'h1;
        nxt_bph  = bph_ff;
        if (bcnt_ff >= 32'(BLINK_HALF - 1)) begin
            nxt_bcnt = 32'h0;
            nxt_bph  = ~bph_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pcnt_ff <= 32'h0;
            bcnt_ff <= 32'h0;
            pph_ff  <= 1'b0;
            bph_ff  <= 1'b0;
        end else begin
            pcnt_ff <= nxt_pcnt;
            bcnt_ff <= nxt_bcnt;
            pph_ff  <= nxt_pph;
            bph_ff  <= nxt_bph;
        end
    end

    assign tk.pulse_phase = pph_ff;
    assign tk.blink_phase = bph_ff;
endmodule
`default_nettype wire

/* File: core/psal_sticky.sv */
// sticky status bits with set-over-clear
`timescale 1ns/1ns
`default_nettype none
module psal_sticky #(
    parameter int W = psal_pkg::STICKY_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // events and clear
    input  wire logic [W-1:0] set_in,
    input  wire logic         clear,
    output logic      [W-1:0] q
);
    logic [W-1:0] st_ff, nxt_st;

    always_comb begin
        nxt_st = (clear ? '0 : st_ff) | set_in; // [R9] [R14]
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= W'(psal_pkg::STICKY_RST);
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff;

    a_sticky_hold: assert property (@(posedge clk) disable iff (reset) // [R9]
        (!clear && st_ff != '0) |=> ((st_ff & $past(st_ff)) == $past(st_ff)))
        else $error("sticky bit dropped without clear");
    a_sticky_reassert: assert property (@(posedge clk) disable iff (reset) // [R14]
        (clear && set_in != '0) |=> ((st_ff & $past(set_in)) == $past(set_in)))
        else $error("persisting fault lost at clear");
endmodule
`default_nettype wire

/* File: core/psal_top.sv */
// status, alarm and indicator logic of the power supply
//
// Contract
// R1 - warning low when output loss imminent
// R2 - fault output low while fault present
// R3 - output on when control tied ground
// R4 - open protocol select means PMBus mode
// R5 - address low bits from select levels
// R6 - warning pulses 1ms period during overload
// R7 - two fan faults shut down immediately
// R8 - input led steady ok, blink out-of-limits
// R9 - sticky bits hold until host clears
// R10 - oring test result held until clear
// R11 - shutdown status latched until cleared
// R12 - warning and fault bits all latch
// R13 - response settings change only by command
// R14 - persisting fault sets again after clear
// R15 - operational status bits track, never latch
// R16 - output led steady ok, blink overload
// R17 - alert low requests host attention
`timescale 1ns/1ns
`default_nettype none
module psal_top #(
    parameter int PULSE_HALF = psal_pkg::HALF_CYCLES,
    parameter int BLINK_HALF = psal_pkg::BLINK_HALF_CYCLES,
    parameter int AW         = psal_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // pins from the shelf
    input  wire logic          output_control_n,
    input  wire logic          protocol_open,
    input  wire logic [AW-1:0] unit_address_level,
    input  wire logic [AW-1:0] rack_address_level,
    // internal conditions
    input  wire logic          output_loss_imminent,
    input  wire logic          overload,
    input  wire logic          input_ok,
    input  wire logic          input_present,
    input  wire logic          output_in_reg,
    input  wire logic [1:0]    fan_fault,
    input  wire logic          ov_fault,
    input  wire logic          uv_fault,
    input  wire logic          oc_fault,
    input  wire logic          ot_fault,
    input  wire logic          unknown_fault,
    input  wire logic          cml_error,
    input  wire logic          int_ext_fault,
    input  wire logic          shutdown_req,
    input  wire logic          oring_pass,
    input  wire logic          oring_fail,
    input  wire logic          alert_req,
    // host commands
    input  wire logic          clear_faults,
    input  wire logic          resp_write,
    input  wire logic [1:0]    oc_resp_in,
    input  wire logic [1:0]    ot_resp_in,
    // open-drain alarm pins
    output logic               power_good_warning_n_o,
    output logic               power_good_warning_n_oe,
    output logic               fault_n_o,
    output logic               fault_n_oe,
    output logic               alert_n_o,
    output logic               alert_n_oe,
    // control and status
    output logic               main_output_on,
    output logic               pmbus_mode,
    output logic [AW-1:0]      unit_addr_bits,
    output logic [AW-1:0]      rack_addr_bits,
    output logic               input_led,
    output logic               output_led,
    output logic [11:0]        sticky_status,
    output logic               status_input_ok,
    output logic               status_output_on,
    output logic [1:0]         oc_response,
    output logic [1:0]         ot_response
);
    psal_tick_if tk ();

    psal_timer #(
        .PULSE_HALF (PULSE_HALF),
        .BLINK_HALF (BLINK_HALF)
    ) u_timer (
        .clk   (clk),
        .reset (reset),
        .tk    (tk)
    );

    logic [11:0] set_vec;
    logic [11:0] st_q;
    logic        dual_fan;
    logic        fault_now;
    logic        shut_now;

    assign dual_fan = &fan_fault;
    assign shut_now = shutdown_req | dual_fan | ov_fault; // [R7]

    always_comb begin
        set_vec = 12'h000;
        set_vec[psal_pkg::ST_OV]      = ov_fault; // [R12]
        set_vec[psal_pkg::ST_UV]      = uv_fault;
        set_vec[psal_pkg::ST_OC]      = oc_fault;
        set_vec[psal_pkg::ST_FAN]     = |fan_fault;
        set_vec[psal_pkg::ST_INPUT]   = input_present & ~input_ok;
        set_vec[psal_pkg::ST_UNKNOWN] = unknown_fault;
        set_vec[psal_pkg::ST_CML]     = cml_error;
        set_vec[psal_pkg::ST_INTEXT]  = int_ext_fault;
        set_vec[psal_pkg::ST_SHUTDN]  = shut_now; // [R11]
        set_vec[psal_pkg::ST_ORPASS]  = oring_pass; // [R10]
        set_vec[psal_pkg::ST_ORFAIL]  = oring_fail; // [R10]
        set_vec[psal_pkg::ST_OT]      = ot_fault;
    end

    psal_sticky #(
        .W (12)
    ) u_sticky (
        .clk    (clk),
        .reset  (reset),
        .set_in (set_vec),
        .clear  (clear_faults),
        .q      (st_q)
    );

    assign fault_now = ov_fault | dual_fan | ot_fault | int_ext_fault | shutdown_req;

    logic        pgw_ff,  nxt_pgw;
    logic        flt_ff,  nxt_flt;
    logic        alr_ff,  nxt_alr;
    logic        on_ff,   nxt_on;
    logic        pm_ff,   nxt_pm;
    logic [AW-1:0] ua_ff, nxt_ua;
    logic [AW-1:0] ra_ff, nxt_ra;
    logic        iled_ff, nxt_iled;
    logic        oled_ff, nxt_oled;
    logic [11:0] sst_ff,  nxt_sst;
    logic        sin_ff,  nxt_sin;
    logic        son_ff,  nxt_son;
    logic [1:0]  ocr_ff,  nxt_ocr;
    logic [1:0]  otr_ff,  nxt_otr;

    always_comb begin
        // alarm registers hold the pin drive enables, so the pins come from flops
        nxt_pgw = 1'b0; // [R1]
        if (overload) begin
            nxt_pgw = ~tk.pulse_phase; // [R6]
        end else if (output_loss_imminent || shut_now) begin
            nxt_pgw = 1'b1; // [R1]
        end
        nxt_flt  = fault_now; // [R2]
        nxt_alr  = alert_req | (|st_q); // [R17]
        nxt_on   = ~output_control_n & ~shut_now; // [R3] [R7]
        nxt_pm   = protocol_open; // [R4]
        nxt_ua   = unit_address_level; // [R5]
        nxt_ra   = rack_address_level; // [R5]
        nxt_iled = input_ok | (input_present & tk.blink_phase); // [R8]
        nxt_oled = overload ? tk.blink_phase : output_in_reg; // [R16]
        nxt_sst  = st_q;
        nxt_sin  = input_ok; // [R15]
        nxt_son  = ~output_control_n & ~shut_now; // [R15]
        nxt_ocr  = resp_write ? oc_resp_in : ocr_ff; // [R13]
        nxt_otr  = resp_write ? ot_resp_in : otr_ff; // [R13]
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pgw_ff  <= 1'b0;
            flt_ff  <= 1'b0;
            alr_ff  <= 1'b0;
            on_ff   <= 1'b0;
            pm_ff   <= 1'b1;
            ua_ff   <= '0;
            ra_ff   <= '0;
            iled_ff <= 1'b0;
            oled_ff <= 1'b0;
            sst_ff  <= psal_pkg::STICKY_RST;
            sin_ff  <= 1'b0;
            son_ff  <= 1'b0;
            ocr_ff  <= psal_pkg::RESP_RST;
            otr_ff  <= psal_pkg::RESP_RST;
        end else begin
            pgw_ff  <= nxt_pgw;
            flt_ff  <= nxt_flt;
            alr_ff  <= nxt_alr;
            on_ff   <= nxt_on;
            pm_ff   <= nxt_pm;
            ua_ff   <= nxt_ua;
            ra_ff   <= nxt_ra;
            iled_ff <= nxt_iled;
            oled_ff <= nxt_oled;
            sst_ff  <= nxt_sst;
            sin_ff  <= nxt_sin;
            son_ff  <= nxt_son;
            ocr_ff  <= nxt_ocr;
            otr_ff  <= nxt_otr;
        end
    end

    // open drain: output fixed low, enable drives the pin low
    assign power_good_warning_n_o  = 1'b0;
    assign power_good_warning_n_oe = pgw_ff;
    assign fault_n_o               = 1'b0;
    assign fault_n_oe              = flt_ff;
    assign alert_n_o               = 1'b0;
    assign alert_n_oe              = alr_ff;
    assign main_output_on          = on_ff;
    assign pmbus_mode              = pm_ff;
    assign unit_addr_bits          = ua_ff;
    assign rack_addr_bits          = ra_ff;
    assign input_led               = iled_ff;
    assign output_led              = oled_ff;
    assign sticky_status           = sst_ff;
    assign status_input_ok         = sin_ff;
    assign status_output_on        = son_ff;
    assign oc_response             = ocr_ff;
    assign ot_response             = otr_ff;

    a_fault_pin: assert property (@(posedge clk) disable iff (reset) // [R2]
        fault_now |=> fault_n_oe)
        else $error("fault pin not driven low");

    a_fault_idle: assert property (@(posedge clk) disable iff (reset) // [R2]
        !fault_now |=> !fault_n_oe)
        else $error("fault pin driven without fault");

    a_warn_idle: assert property (@(posedge clk) disable iff (reset) // [R1]
        (!overload && !output_loss_imminent && !shut_now) |=> !power_good_warning_n_oe)
        else $error("warning driven without cause");

    a_warn_loss: assert property (@(posedge clk) disable iff (reset) // [R1]
        (!overload && output_loss_imminent) |=> power_good_warning_n_oe)
        else $error("warning not asserted on imminent loss");

    a_warn_pulse: assert property (@(posedge clk) disable iff (reset) // [R6]
        overload |=> (power_good_warning_n_oe == !$past(tk.pulse_phase)))
        else $error("warning not following overload pulse");

    a_dual_fan: assert property (@(posedge clk) disable iff (reset) // [R7]
        (&fan_fault) |=> !main_output_on)
        else $error("output on with two fans failed");

    a_shut_off: assert property (@(posedge clk) disable iff (reset) // [R7]
        shut_now |=> !main_output_on)
        else $error("output on during shutdown");

    a_output_ctl: assert property (@(posedge clk) disable iff (reset) // [R3]
        (!output_control_n && !shut_now) |=> main_output_on)
        else $error("output not on with control grounded");

    a_proto_sel: assert property (@(posedge clk) disable iff (reset) // [R4]
        1'b1 |=> (pmbus_mode == $past(protocol_open)))
        else $error("protocol mode mismatch");

    a_addr_unit: assert property (@(posedge clk) disable iff (reset) // [R5]
        1'b1 |=> (unit_addr_bits == $past(unit_address_level)))
        else $error("unit address bits mismatch");

    a_addr_rack: assert property (@(posedge clk) disable iff (reset) // [R5]
        1'b1 |=> (rack_addr_bits == $past(rack_address_level)))
        else $error("rack address bits mismatch");

    a_shut_status: assert property (@(posedge clk) disable iff (reset) // [R11]
        shut_now |=> st_q[psal_pkg::ST_SHUTDN])
        else $error("shutdown status not latched");

    a_status_copy: assert property (@(posedge clk) disable iff (reset) // [R12]
        1'b1 |=> (sticky_status == $past(st_q)))
        else $error("status copy lags");

    a_resp_keep: assert property (@(posedge clk) disable iff (reset) // [R13]
        (!resp_write ##1 1'b1) |-> $stable(oc_response) && $stable(ot_response))
        else $error("response setting changed without command");

    a_resp_load: assert property (@(posedge clk) disable iff (reset) // [R13]
        resp_write |=> (oc_response == $past(oc_resp_in)) && (ot_response == $past(ot_resp_in)))
        else $error("response setting not loaded");

    a_status_track: assert property (@(posedge clk) disable iff (reset) // [R15]
        (!input_ok ##1 1'b1) |-> !status_input_ok)
        else $error("operational status latched");

    a_status_on: assert property (@(posedge clk) disable iff (reset) // [R15]
        (!output_control_n && !shut_now) |=> status_output_on)
        else $error("output status not tracking");

    a_alert_pin: assert property (@(posedge clk) disable iff (reset) // [R17]
        alert_req |=> alert_n_oe)
        else $error("alert not asserted");

    a_alert_sticky: assert property (@(posedge clk) disable iff (reset) // [R17]
        (st_q != '0) |=> alert_n_oe)
        else $error("alert not asserted on latched status");

    a_alert_idle: assert property (@(posedge clk) disable iff (reset) // [R17]
        (!alert_req && st_q == '0) |=> !alert_n_oe)
        else $error("alert driven without cause");

    a_input_led: assert property (@(posedge clk) disable iff (reset) // [R8]
        input_ok |=> input_led)
        else $error("input led not steady");

    a_input_blink: assert property (@(posedge clk) disable iff (reset) // [R8]
        (!input_ok && input_present) |=> (input_led == $past(tk.blink_phase)))
        else $error("input led not blinking");

    a_output_led: assert property (@(posedge clk) disable iff (reset) // [R16]
        !overload |=> (output_led == $past(output_in_reg)))
        else $error("output led not tracking regulation");

    a_overload_led: assert property (@(posedge clk) disable iff (reset) // [R16]
        overload |=> (output_led == $past(tk.blink_phase)))
        else $error("output led not blinking in overload");
endmodule
`default_nettype wire

/* File: verification/psal_shelf_model.sv */
// shelf controller model: alarm pin pull-ups and output strapping
`timescale 1ns/1ns
`default_nettype none
module psal_shelf_model (
    // strapping chosen by the bench
    input  wire logic tie_on,
    input  wire logic leave_open,
    // alarm pin drivers of the unit
    input  wire logic power_good_warning_n_o,
    input  wire logic power_good_warning_n_oe,
    input  wire logic fault_n_o,
    input  wire logic fault_n_oe,
    input  wire logic alert_n_o,
    input  wire logic alert_n_oe,
    // levels seen on the shelf
    output logic      output_control_n,
    output logic      protocol_open,
    output logic      warning_pin,
    output logic      fault_pin,
    output logic      alert_pin
);
    assign output_control_n = tie_on ? 1'b0 : 1'b1;
    assign protocol_open    = leave_open;
    // released pins sit at the pull-up level
    assign warning_pin = power_good_warning_n_oe ? power_good_warning_n_o : 1'b1;
    assign fault_pin = fault_n_oe ? fault_n_o : 1'b1;
    assign alert_pin = alert_n_oe ? alert_n_o : 1'b1;
endmodule
`default_nettype wire

/* File: verification/psal_top_bench.sv */
// self-checking bench for the status and alarm logic
`timescale 1ns/1ns
`default_nettype none
module psal_top_bench;
    localparam int PH = 4;
    localparam int BH = 8;
    typedef struct {int due; int id; logic [11:0] m; logic [11:0] v;} psal_note_t;
    psal_note_t q[$];
    int cyc, err_count, check_count;
    logic clk, reset, tie_on, leave_open, output_control_n, protocol_open;
    logic output_loss_imminent, overload, input_ok, input_present, output_in_reg;
    logic ov_fault, uv_fault, oc_fault, ot_fault, unknown_fault, cml_error, int_ext_fault;
    logic shutdown_req, oring_pass, oring_fail, alert_req, clear_faults, resp_write;
    logic [1:0] fan_fault, oc_resp_in, ot_resp_in, oc_response, ot_response;
    logic [3:0] unit_address_level, rack_address_level, unit_addr_bits, rack_addr_bits;
    logic power_good_warning_n_o, power_good_warning_n_oe, fault_n_o, fault_n_oe;
    logic alert_n_o, alert_n_oe, warning_pin, fault_pin, alert_pin;
    logic main_output_on, pmbus_mode, input_led, output_led, status_input_ok, status_output_on;
    logic [11:0] sticky_status, m;
    int bits[11] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11};

    psal_top #(.PULSE_HALF(PH), .BLINK_HALF(BH)) i_dut (.*);
    psal_shelf_model i_shelf (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [11:0] obs(int id);
        case (id)
            0: return {11'h0, fault_pin};
            1: return {11'h0, warning_pin};
            2: return {11'h0, alert_pin};
            3: return {11'h0, main_output_on};
            4: return {11'h0, pmbus_mode};
            5: return {4'h0, rack_addr_bits, unit_addr_bits};
            6: return {11'h0, input_led};
            7: return {11'h0, output_led};
            8: return sticky_status;
            9: return {10'h0, status_input_ok, status_output_on};
            default: return {8'h0, oc_response, ot_response};
        endcase
    endfunction

    task automatic st(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic note(int lat, int id, logic [11:0] mk, logic [11:0] v);
        q.push_back('{cyc + lat, id, mk, v});
    endtask

    task automatic cmp_val(int id, logic [11:0] e, logic [11:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t result %0d expected %h got %h", $time, id, e, g);
        end
    endtask

    task automatic set_cond(int b, logic x);
        case (b)
            0: ov_fault = x;
            1: uv_fault = x;
            2: oc_fault = x;
            3: fan_fault[0] = x;
            5: unknown_fault = x;
            6: cml_error = x;
            7: int_ext_fault = x;
            8: shutdown_req = x;
            9: oring_pass = x;
            10: oring_fail = x;
            default: ot_fault = x;
        endcase
    endtask

    task automatic pulse_clear();
        clear_faults = 1'b1;
        st(1);
        clear_faults = 1'b0;
    endtask

    // checks that a level toggles with the given half period
    task automatic blink(int id, int half, int n);
        int last, edges, bad;
        logic [11:0] p, c;
        last = -1;
        edges = 0;
        bad = 0;
        p = obs(id);
        for (int i = 0; i < n; i++) begin
            st(1);
            c = obs(id);
            if (c !== p) begin
                if (last >= 0 && i - last != half) bad++;
                last = i;
                edges++;
            end
            p = c;
        end
        cmp_val(id, 12'h0, (edges < 3 || bad > 0) ? 12'h1 : 12'h0);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            final_report();
        end
    end

    // result watcher: oldest note first
    always @(negedge clk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            cmp_val(q[0].id, q[0].v, obs(q[0].id) & q[0].m);
            void'(q.pop_front());
        end
    end

    initial begin
        cyc = 0;
        {tie_on, leave_open, unit_address_level, rack_address_level} = '0;
        {output_loss_imminent, overload, input_ok, input_present, output_in_reg} = '0;
        {ov_fault, uv_fault, oc_fault, ot_fault, unknown_fault, cml_error, int_ext_fault} = '0;
        {shutdown_req, oring_pass, oring_fail, alert_req, clear_faults, resp_write} = '0;
        {fan_fault, oc_resp_in, ot_resp_in} = '0;
        reset = 1'b1;
        void'($urandom(22));
        st(6);
        reset = 1'b0;
        note(0, 0, 12'hfff, 12'h1);
        note(0, 2, 12'hfff, 12'h1);
        note(0, 4, 12'hfff, 12'h1);
        note(0, 8, 12'hfff, 12'h0);
        note(0, 10, 12'hfff, 12'h0);
        st(1);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            {tie_on, leave_open, unit_address_level, rack_address_level} = 10'($urandom());
            note(1, 3, 12'hfff, {11'h0, tie_on});
            note(1, 4, 12'hfff, {11'h0, leave_open});
            note(1, 5, 12'hfff, {4'h0, rack_address_level, unit_address_level});
            st(1);
        end
        tie_on = 1'b1;
        output_loss_imminent = 1'b1;
        note(1, 1, 12'hfff, 12'h0);
        st(2);
        output_loss_imminent = 1'b0;
        note(1, 1, 12'hfff, 12'h1);
        st(2);
        fan_fault = 2'h1;
        note(1, 0, 12'hfff, 12'h1);
        note(1, 3, 12'hfff, 12'h1);
        st(2);
        fan_fault = 2'h3;
        note(1, 0, 12'hfff, 12'h0);
        note(1, 3, 12'hfff, 12'h0);
        st(2);
        fan_fault = 2'h0;
        note(1, 0, 12'hfff, 12'h1);
        st(2);
        pulse_clear();
        st(3);
        $display("test pins done");
        foreach (bits[k]) begin
            m = 12'h1 << bits[k];
            set_cond(bits[k], 1'b1);
            st(1);
            set_cond(bits[k], 1'b0);
            note(1, 8, m, m);
            note(1, 2, 12'hfff, 12'h0);
            st(3);
            note(0, 8, m, m);
            pulse_clear();
            note(1, 8, 12'hfff, 12'h0);
            note(1, 2, 12'hfff, 12'h1);
            st(3);
        end
        ot_fault = 1'b1;
        st(3);
        pulse_clear();
        note(1, 8, 12'h800, 12'h800);
        st(2);
        ot_fault = 1'b0;
        pulse_clear();
        note(1, 8, 12'h800, 12'h000);
        alert_req = 1'b1;
        note(1, 2, 12'hfff, 12'h0);
        st(1);
        alert_req = 1'b0;
        st(3);
        $display("test sticky done");
        for (int i = 0; i < 4; i++) begin
            {oc_resp_in, ot_resp_in} = 4'($urandom());
            resp_write = 1'b1;
            note(1, 10, 12'hfff, {8'h0, oc_resp_in, ot_resp_in});
            st(1);
            resp_write = 1'b0;
            clear_faults = 1'b1;
            oc_resp_in = ~oc_resp_in;
            note(1, 10, 12'hfff, {8'h0, ~oc_resp_in, ot_resp_in});
            st(1);
            clear_faults = 1'b0;
        end
        $display("test responses done");
        input_ok = 1'b1;
        output_in_reg = 1'b1;
        note(1, 9, 12'h3, 12'h3);
        note(1, 6, 12'hfff, 12'h1);
        note(1, 7, 12'hfff, 12'h1);
        st(2);
        input_ok = 1'b0;
        input_present = 1'b1;
        note(1, 9, 12'h3, 12'h1);
        note(2, 8, 12'h010, 12'h010);
        st(2);
        blink(6, BH, 40);
        overload = 1'b1;
        st(2);
        blink(1, PH, 24);
        blink(7, BH, 40);
        overload = 1'b0;
        st(3);
        $display("test indicators done");
        final_report();
    end
endmodule
`default_nettype wire
